// >>> rtl/dmag_pkg.sv
package dmag_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int BANK_W = 4;
    localparam int PAIRS = 3;
    localparam int PAIR_STRIDE = 8;
    localparam int PAIR_SPAN = 7;
    localparam int HIGH_W = 4;
    localparam int A_BIT = 8;
    localparam int D_BIT = 9;
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 10;
    localparam logic [11:0] PAIR0_BASE = 12'hFEF;
    localparam logic [11:0] FORCED_BASE = 12'hF00;
    localparam logic [11:0] BANK0_BASE = 12'h000;
    localparam logic [11:0] PTR_RESET = 12'h000;
    localparam logic [11:0] PTR_ONE = 12'h001;
    localparam logic [7:0] ILO_LIMIT = 8'h5F;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [3:0] ZERO_NIB = 4'h0;
    localparam logic [5:0] OPC_ADD_ACCUM_TO_FILE = 6'h09;
    localparam logic [2:0] OFS_PLAIN = 3'h0;
    localparam logic [2:0] OFS_POST_INCREMENT_OPERAND = 3'h1;
    localparam logic [2:0] OFS_POST_DECREMENT_OPERAND = 3'h2;
    localparam logic [2:0] OFS_PRE_INCREMENT_OPERAND = 3'h3;
    localparam logic [2:0] OFS_OFFSET_BY_ACCUM_OPERAND = 3'h4;
    localparam logic [2:0] OFS_HIGH = 3'h5;
    localparam logic [2:0] OFS_LOW = 3'h6;

    typedef struct packed {
        logic hit;
        logic [1:0] pair;
        logic [2:0] ofs;
    } dmag_hit_t;

    typedef enum logic [1:0] {
        KIND_MEM,
        KIND_PTR_HIGH,
        KIND_PTR_LOW,
        KIND_VOID
    } dmag_kind_t;
endpackage

// >>> rtl/dmag_addr_gen.sv
`timescale 1ns/10ps
`default_nettype none
module dmag_addr_gen (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic extended_set_enable,
    input wire logic req,
    input wire logic wr,
    input wire logic byte_bit_op,
    input wire logic [dmag_pkg::INSTR_W-1:0] instr,
    input wire logic [dmag_pkg::ADDR_W-1:0] full_addr,
    input wire logic [dmag_pkg::DATA_W-1:0] wdata,
    input wire logic [dmag_pkg::DATA_W-1:0] accum,
    input wire logic [dmag_pkg::BANK_W-1:0] bank_select_register,
    input wire logic [dmag_pkg::DATA_W-1:0] mem_rdata,
    output logic [dmag_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [dmag_pkg::DATA_W-1:0] mem_wdata,
    output logic rvalid,
    output logic [dmag_pkg::DATA_W-1:0] rdata,
    output logic dec_add_accum_to_file,
    output logic dest_to_file,
    output logic ilo_active,
    output logic ext_decode_en,
    output logic [dmag_pkg::ADDR_W-1:0] pointer_pair_0,
    output logic [dmag_pkg::ADDR_W-1:0] pointer_pair_1,
    output logic [dmag_pkg::ADDR_W-1:0] pointer_pair_2
);
    import dmag_pkg::*;

    // which pointer slot an address hits
    function automatic dmag_hit_t sfr_hit(input logic [ADDR_W-1:0] addr);
        dmag_hit_t r;
        logic [ADDR_W-1:0] diff;
        r = '0;
        diff = '0;
        for (int n = 0; n < PAIRS; n++) begin
            diff = ADDR_W'(int'(PAIR0_BASE) - PAIR_STRIDE * n - int'(addr));
            if (diff < ADDR_W'(PAIR_SPAN)) begin
                r.hit = 1'b1;
                r.pair = 2'(n);
                r.ofs = diff[2:0];
            end
        end
        return r;
    endfunction

    logic [ADDR_W-1:0] ptr [PAIRS];
    logic [DATA_W-1:0] fld;
    logic acc_bit;
    logic [ADDR_W-1:0] dir_addr;
    logic ilo;
    dmag_hit_t hit1;
    dmag_hit_t hit2;
    logic virt1;
    logic [ADDR_W-1:0] ind_ptr;
    logic [ADDR_W-1:0] ind_addr;
    logic [ADDR_W-1:0] eff_addr;
    dmag_kind_t kind;
    logic ptr_write;
    logic adj_mode;
    logic [DATA_W-1:0] local_data;
    logic resp_pend;
    logic resp_local;
    logic [DATA_W-1:0] resp_data;

    assign fld = instr[DATA_W-1:0];
    assign acc_bit = instr[A_BIT];

    // direct address formation
    always_comb begin
        ilo = 1'b0;
        if (!byte_bit_op) begin
            dir_addr = full_addr;
        end else if (acc_bit) begin
            dir_addr = {bank_select_register, fld};
        end else if (fld <= ILO_LIMIT) begin
            if (extended_set_enable) begin
                ilo = 1'b1;
                dir_addr = ptr[2] + {ZERO_NIB, fld};
            end else begin
                dir_addr = BANK0_BASE | {ZERO_NIB, fld};
            end
        end else begin
            dir_addr = FORCED_BASE | {ZERO_NIB, fld};
        end
    end

    // indirect resolution, same for every pair in both modes
    assign hit1 = sfr_hit(dir_addr);
    assign virt1 = hit1.hit && (hit1.ofs <= OFS_OFFSET_BY_ACCUM_OPERAND);
    assign ind_ptr = ptr[hit1.pair];

    always_comb begin
        case (hit1.ofs)
            OFS_PRE_INCREMENT_OPERAND: ind_addr = ind_ptr + PTR_ONE;
            OFS_OFFSET_BY_ACCUM_OPERAND: ind_addr = ind_ptr + {{HIGH_W{accum[DATA_W-1]}}, accum};
            default: ind_addr = ind_ptr;
        endcase
    end

    assign eff_addr = virt1 ? ind_addr : dir_addr;
    assign hit2 = sfr_hit(eff_addr);

    always_comb begin
        if (virt1 && hit2.hit && hit2.ofs <= OFS_OFFSET_BY_ACCUM_OPERAND) begin
            kind = KIND_VOID;
        end else if (hit2.hit && hit2.ofs == OFS_HIGH) begin
            kind = KIND_PTR_HIGH;
        end else if (hit2.hit && hit2.ofs == OFS_LOW) begin
            kind = KIND_PTR_LOW;
        end else begin
            kind = KIND_MEM;
        end
    end

    assign ptr_write = req && wr && (kind == KIND_PTR_HIGH || kind == KIND_PTR_LOW);
    assign adj_mode = virt1 && (hit1.ofs == OFS_POST_INCREMENT_OPERAND || hit1.ofs == OFS_POST_DECREMENT_OPERAND
        || hit1.ofs == OFS_PRE_INCREMENT_OPERAND);

    // pointer pairs
    generate
        for (genvar n = 0; n < PAIRS; n++) begin : g_ptr
            logic wr_this;
            logic adj_this;
            assign wr_this = ptr_write && hit2.pair == 2'(n);
            assign adj_this = req && adj_mode && hit1.pair == 2'(n);
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    ptr[n] <= PTR_RESET;
                end else if (wr_this) begin
                    if (kind == KIND_PTR_HIGH) begin
                        ptr[n] <= {wdata[HIGH_W-1:0], ptr[n][DATA_W-1:0]};
                    end else begin
                        ptr[n] <= {ptr[n][ADDR_W-1:DATA_W], wdata};
                    end
                end else if (adj_this) begin
                    if (hit1.ofs == OFS_POST_DECREMENT_OPERAND) begin
                        ptr[n] <= ptr[n] - PTR_ONE;
                    end else begin
                        ptr[n] <= ptr[n] + PTR_ONE;
                    end
                end
            end
        end
    endgenerate

    assign pointer_pair_0 = ptr[0];
    assign pointer_pair_1 = ptr[1];
    assign pointer_pair_2 = ptr[2];

    // memory strobes
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            mem_addr <= PTR_RESET;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= ZERO_BYTE;
        end else begin
            mem_rd <= req && !wr && kind == KIND_MEM;
            mem_wr <= req && wr && kind == KIND_MEM;
            if (req) begin
                mem_addr <= eff_addr;
                mem_wdata <= wdata;
            end
        end
    end

    always_comb begin
        case (kind)
            KIND_PTR_HIGH: local_data = {ZERO_NIB, ptr[hit2.pair][ADDR_W-1:DATA_W]};
            KIND_PTR_LOW: local_data = ptr[hit2.pair][DATA_W-1:0];
            default: local_data = ZERO_BYTE;
        endcase
    end

    // read answer two edges after the request
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            resp_pend <= 1'b0;
            resp_local <= 1'b0;
            resp_data <= ZERO_BYTE;
            rvalid <= 1'b0;
            rdata <= ZERO_BYTE;
        end else begin
            resp_pend <= req;
            resp_local <= kind != KIND_MEM;
            resp_data <= local_data;
            rvalid <= resp_pend;
            if (resp_pend) begin
                rdata <= resp_local ? resp_data : mem_rdata;
            end
        end
    end

    // instruction side decode
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            dec_add_accum_to_file <= 1'b0;
            dest_to_file <= 1'b0;
            ilo_active <= 1'b0;
            ext_decode_en <= 1'b0;
        end else begin
            ext_decode_en <= extended_set_enable;
            if (req) begin
                dec_add_accum_to_file <= instr[OPC_MSB:OPC_LSB] == OPC_ADD_ACCUM_TO_FILE;
                dest_to_file <= byte_bit_op && instr[D_BIT];
                ilo_active <= ilo;
            end
        end
    end

    logic own_wr;
    assign own_wr = ptr_write && hit2.pair == hit1.pair;

    AST_PLAIN_ADDR: assert property (@(posedge mclk) disable iff (!resetn)
        req && virt1 && hit1.ofs == OFS_PLAIN && kind == KIND_MEM
        |=> mem_addr == $past(ind_ptr) && ptr[$past(hit1.pair)] == $past(ind_ptr))
        else $error("plain indirect address or pointer wrong");

    AST_POST_DECREMENT_OPERAND: assert property (@(posedge mclk) disable iff (!resetn)
        req && virt1 && hit1.ofs == OFS_POST_DECREMENT_OPERAND && !own_wr
        |=> ptr[$past(hit1.pair)] == $past(ind_ptr) - PTR_ONE
            && (!mem_rd && !mem_wr || mem_addr == $past(ind_ptr)))
        else $error("post-decrement wrong");

    AST_POST_INCREMENT_OPERAND: assert property (@(posedge mclk) disable iff (!resetn)
        req && virt1 && hit1.ofs == OFS_POST_INCREMENT_OPERAND && !own_wr
        |=> ptr[$past(hit1.pair)] == $past(ind_ptr) + PTR_ONE
            && (!mem_rd && !mem_wr || mem_addr == $past(ind_ptr)))
        else $error("post-increment wrong");

    AST_PRE_INCREMENT_OPERAND: assert property (@(posedge mclk) disable iff (!resetn)
        req && virt1 && hit1.ofs == OFS_PRE_INCREMENT_OPERAND && kind == KIND_MEM
        |=> mem_addr == ptr[$past(hit1.pair)])
        else $error("pre-increment address is not the new pointer");

    AST_OFFSET_BY_ACCUM_OPERAND: assert property (@(posedge mclk) disable iff (!resetn)
        req && virt1 && hit1.ofs == OFS_OFFSET_BY_ACCUM_OPERAND && kind == KIND_MEM && !ptr_write
        |=> mem_addr == $past(ind_ptr) + {{HIGH_W{$past(accum[DATA_W-1])}}, $past(accum)}
            && ptr[$past(hit1.pair)] == $past(ind_ptr))
        else $error("offset-by-accumulator wrong");

    AST_VOID: assert property (@(posedge mclk) disable iff (!resetn)
        req && kind == KIND_VOID
        |=> !mem_rd && !mem_wr ##1 rvalid && rdata == ZERO_BYTE)
        else $error("virtual target not void");

    AST_OWN_WRITE: assert property (@(posedge mclk) disable iff (!resetn)
        req && own_wr && kind == KIND_PTR_LOW
        |=> ptr[$past(hit1.pair)][DATA_W-1:0] == $past(wdata))
        else $error("self write was adjusted");

    AST_LONG: assert property (@(posedge mclk) disable iff (!resetn)
        req && byte_bit_op && acc_bit && kind == KIND_MEM && !virt1
        |=> mem_addr == {$past(bank_select_register), $past(fld)})
        else $error("direct long address wrong");

    AST_ILO: assert property (@(posedge mclk) disable iff (!resetn)
        req && ilo && kind == KIND_MEM && !virt1
        |=> ilo_active && mem_addr == $past(ptr[2]) + {ZERO_NIB, $past(fld)})
        else $error("indexed literal offset address wrong");

    AST_FORCED: assert property (@(posedge mclk) disable iff (!resetn)
        req && byte_bit_op && !acc_bit && fld > ILO_LIMIT && kind == KIND_MEM && !virt1
        |=> mem_addr == (FORCED_BASE | {ZERO_NIB, $past(fld)}))
        else $error("forced address wrong");

    AST_PTR_BYTE_LOCAL: assert property (@(posedge mclk) disable iff (!resetn)
        req && (kind == KIND_PTR_HIGH || kind == KIND_PTR_LOW)
        |=> !mem_rd && !mem_wr ##1 rvalid)
        else $error("pointer byte access reached memory");

    AST_HIGH_NIBBLE: assert property (@(posedge mclk) disable iff (!resetn)
        req && !wr && kind == KIND_PTR_HIGH
        |=> ##1 rvalid && rdata[DATA_W-1:HIGH_W] == ZERO_NIB)
        else $error("pointer high byte upper bits not zero");

endmodule // dmag_addr_gen
`default_nettype wire

// >>> sim/dmag_ram_model.sv
`timescale 1ns/10ps
`default_nettype none
module dmag_ram_model (
    input wire logic mclk,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] last = 8'h00;
    // preset pattern, bench shadow uses the same
    initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'hA5;
    // idle bus shows inverse of last data
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
    always @(posedge mclk) begin
        if (mem_wr) mem[mem_addr] <= mem_wdata;
        if (mem_rd) last <= mem[mem_addr];
    end
endmodule // dmag_ram_model
`default_nettype wire

// >>> sim/data_memory_address_generator_bench.sv
`timescale 1ns/10ps
`default_nettype none
module data_memory_address_generator_bench;
    import dmag_pkg::*;
    logic mclk = 0, resetn = 0, extended_set_enable = 0, req = 0, wr = 0, byte_bit_op = 0;
    logic [15:0] instr = 0;
    logic [11:0] full_addr = 0, mem_addr, pointer_pair_0, pointer_pair_1, pointer_pair_2;
    logic [7:0] wdata = 0, accum = 0, mem_rdata, mem_wdata, rdata;
    logic [3:0] bank_select_register = 0;
    logic mem_rd, mem_wr, rvalid, dec_add_accum_to_file, dest_to_file, ilo_active, ext_decode_en;
    int num_errors = 0, num_checks = 0;
    logic [11:0] p [3] = '{default: 12'h000};
    logic [7:0] sh [0:4095];
    logic [11:0] v;
    logic [7:0] f;
    logic [15:0] ins;
    dmag_addr_gen dmag_addr_gen_i (.mclk, .resetn, .extended_set_enable, .req, .wr, .byte_bit_op,
        .instr, .full_addr, .wdata, .accum, .bank_select_register, .mem_rdata, .mem_addr,
        .mem_rd, .mem_wr, .mem_wdata, .rvalid, .rdata, .dec_add_accum_to_file, .dest_to_file,
        .ilo_active, .ext_decode_en, .pointer_pair_0, .pointer_pair_1, .pointer_pair_2);
    dmag_ram_model dmag_ram_model_i (.mclk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
    always #50 mclk = ~mclk;
    task automatic chk(input string s, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask
    // pair and operand slot of an address, n = -1 when none
    function automatic void cls(input logic [11:0] a, output int n, output int o);
        n = -1;
        o = 0;
        for (int i = 0; i < 3; i++) begin
            if (a <= PAIR0_BASE - PAIR_STRIDE * i && a >= PAIR0_BASE - PAIR_STRIDE * i - 6) begin
                n = i;
                o = PAIR0_BASE - PAIR_STRIDE * i - a;
            end
        end
    endfunction
    task automatic acc(input logic w, input logic b, input logic [15:0] ins,
            input logic [11:0] fa, input logic [7:0] wd, input logic [7:0] ac);
        logic [11:0] a, ia;
        logic [11:0] np [3];
        logic [7:0] er;
        logic st, ilo;
        int n, o, m, q;
        np = p;
        er = 8'h00;
        st = 0;
        ilo = b && !ins[8] && ins[7:0] <= 8'h5F && extended_set_enable;
        if (!b) a = fa;
        else if (ins[8]) a = {bank_select_register, ins[7:0]};
        else if (ins[7:0] >= 8'h60) a = FORCED_BASE | ins[7:0];
        else a = (ilo ? p[2] : 12'h000) + ins[7:0];
        cls(a, n, o);
        if (n >= 0 && o <= 4) begin
            ia = p[n];
            case (o)
                1: np[n] = p[n] + 1;
                2: np[n] = p[n] - 1;
                3: begin
                    ia = p[n] + 1;
                    np[n] = ia;
                end
                4: ia = p[n] + {{4{ac[7]}}, ac};
                default: ;
            endcase
            cls(ia, m, q);
        end else begin
            ia = a;
            m = n;
            q = o;
        end
        if (m >= 0 && q <= 4) er = 8'h00;
        else if (m >= 0) begin
            er = (q == 5) ? {4'h0, p[m][11:8]} : p[m][7:0];
            if (w && m == n) np[m] = p[m];
            if (w && q == 5) np[m][11:8] = wd[3:0];
            if (w && q == 6) np[m][7:0] = wd;
        end else begin
            st = 1;
            er = sh[ia];
            if (w) sh[ia] = wd;
        end
        @(negedge mclk);
        {req, wr, byte_bit_op, instr, full_addr, wdata, accum} = {1'b1, w, b, ins, fa, wd, ac};
        @(negedge mclk);
        req = 0;
        chk("mem_rd", st && !w, mem_rd);
        chk("mem_wr", st && w, mem_wr);
        if (st) chk("mem_addr", ia, mem_addr);
        if (st && w) chk("mem_wdata", wd, mem_wdata);
        @(negedge mclk);
        p = np;
        chk("rvalid", 1, rvalid);
        if (!w) chk("rdata", er, rdata);
        chk("ptr0", p[0], pointer_pair_0);
        chk("ptr1", p[1], pointer_pair_1);
        chk("ptr2", p[2], pointer_pair_2);
        chk("opc", ins[15:10] == OPC_ADD_ACCUM_TO_FILE, dec_add_accum_to_file);
        chk("dest", b && ins[9], dest_to_file);
        chk("ilo", ilo, ilo_active);
        chk("ext", extended_set_enable, ext_decode_en);
    endtask
    task automatic setp(input int n, input logic [11:0] v);
        logic [11:0] b;
        b = 12'(PAIR0_BASE - PAIR_STRIDE * n);
        acc(1, 0, 0, b - 12'h006, v[7:0], 0);
        acc(1, 0, 0, b - 12'h005, {4'h0, v[11:8]}, 0);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 4096; i++) sh[i] = 8'(i) ^ 8'hA5;
        void'($urandom(93127));
        repeat (6) @(negedge mclk);
        resetn = 1;
        chk("ptr reset", 12'h000, pointer_pair_0 | pointer_pair_1 | pointer_pair_2);
        for (int k = 0; k < 45; k++) begin
            extended_set_enable = 1'($urandom);
            bank_select_register = 4'($urandom);
            v = (k < 9) ? ((k / 3 == 0) ? 12'hFFF : (k / 3 == 1) ? 12'h0FF : 12'h000)
                : 12'($urandom) & 12'hEFF;
            setp(k % 3, v);
            for (int o = 0; o < 5; o++) begin
                acc(1'($urandom), 0, 16'($urandom), 12'(PAIR0_BASE - PAIR_STRIDE * (k % 3) - o),
                    8'($urandom), 8'($urandom));
            end
        end
        $display("test indirect operands done");
        setp(0, 12'hFE7);
        acc(0, 0, 0, PAIR0_BASE, 0, 0);
        acc(1, 0, 0, PAIR0_BASE, 8'h5A, 0);
        setp(2, 12'hFD9);
        acc(1, 0, 0, 12'hFDD, 8'h3C, 0);
        setp(0, 12'hFE1);
        acc(1, 0, 0, 12'hFEE, 8'h77, 0);
        for (int n = 0; n < 3; n++) setp(n, 12'($urandom) & 12'hEFF);
        $display("test pointer targets done");
        for (int k = 0; k < 200; k++) begin
            extended_set_enable = 1'($urandom);
            bank_select_register = 4'($urandom);
            f = (k < 4) ? ((k == 0) ? 8'h00 : (k == 1) ? 8'h5F : (k == 2) ? 8'h60 : 8'hFF)
                : 8'($urandom);
            ins = {16'($urandom) & 16'hFF00} | f;
            if (k % 4 == 0) ins[15:10] = OPC_ADD_ACCUM_TO_FILE;
            acc($urandom && f < 8'hD0, 1'($urandom), ins, 12'($urandom) & 12'hEFF,
                8'($urandom), 8'($urandom));
        end
        $display("test direct modes done");
        conclude();
    end
endmodule // data_memory_address_generator_bench
`default_nettype wire
